// file: rtl/nvsram_host_ctrl.sv
/*
 * Host-side controller that drives an asynchronous nvSRAM through its pins:
 * array reads and writes with byte selects, six-read software sequences and
 * pin-requested stores.
 * Assumes pin inputs are synchronous to clk and that the bench resolves the
 * data lines and the open-drain busy line from the output enables.
 */
`include "nvsram_host_consts.svh"

module nvsram_host_ctrl
    import nvsram_host_pkg::*;
#(
    parameter int ADDR_W = 19,
    parameter int DATA_W = 16,
    parameter int RECOVERY_CYC = `POST_STORE_RECOVERY_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire op_e cmd_op,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [DATA_W-1:0] cmd_wdata,
    input wire logic [1:0] cmd_byte_sel_n,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic chip_sel_n,
    output logic out_en_n,
    output logic write_strobe_n,
    output logic upper_byte_sel_n,
    output logic lower_byte_sel_n,
    output logic [ADDR_W-1:0] address_lines,
    input wire logic [DATA_W-1:0] data_lines_in,
    output logic [DATA_W-1:0] data_lines_out,
    output logic data_lines_oe,
    input wire logic store_busy_n_in,
    output logic store_busy_n_out,
    output logic store_busy_n_oe
);

    localparam logic [7:0] SETUP_CYC = 8'(`ADDR_SETUP_CYC);
    localparam logic [7:0] ACCESS_CYC = 8'(`ADDRESS_ACCESS_CYC);
    localparam logic [7:0] PULSE_CYC = 8'(`WRITE_PULSE_CYC);
    localparam logic [7:0] REQUEST_CYC = 8'(`BUSY_REQUEST_CYC);
    localparam logic [7:0] START_CYC = 8'(`NV_START_CYC);

    // ------------------------------------------------------------------------
    // Sequence address table
    // ------------------------------------------------------------------------
    function automatic logic [15:0] seq_addr(input logic [2:0] idx, input op_e op);
        logic [15:0] a;
        a = `SEQ_LAST_STORE;
        case (idx)
            3'h0: a = `SEQ_ADDR_0;
            3'h1: a = `SEQ_ADDR_1;
            3'h2: a = `SEQ_ADDR_2;
            3'h3: a = `SEQ_ADDR_3;
            3'h4: a = `SEQ_ADDR_4;
            default: begin
                case (op)
                    OP_SW_RECALL: a = `SEQ_LAST_RECALL;
                    OP_PFS_DISABLE: a = `SEQ_LAST_PFS_OFF;
                    OP_PFS_ENABLE: a = `SEQ_LAST_PFS_ON;
                    default: a = `SEQ_LAST_STORE;
                endcase
            end
        endcase
        return a;
    endfunction

    function automatic logic is_sequence(input op_e op);
        return (op == OP_SW_STORE) || (op == OP_SW_RECALL) ||
               (op == OP_PFS_DISABLE) || (op == OP_PFS_ENABLE);
    endfunction

    // ------------------------------------------------------------------------
    // Busy line guard
    // ------------------------------------------------------------------------
    logic access_ok;

    busy_guard #(
        .RECOVERY_CYC(RECOVERY_CYC)
    ) u_busy_guard (
        .clk(clk),
        .resetn(resetn),
        .store_busy_n_in(store_busy_n_in),
        .access_ok(access_ok)
    );

    // ------------------------------------------------------------------------
    // Pin sequencer
    // ------------------------------------------------------------------------
    state_e state_q, state_d;
    op_e op_q, op_d;
    logic [7:0] cnt_q, cnt_d;
    logic [2:0] idx_q, idx_d;
    logic ce_q, ce_d, oe_q, oe_d, we_q, we_d;
    logic [1:0] bsel_q, bsel_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic doe_q, doe_d, busy_oe_q, busy_oe_d, rsp_q, rsp_d;

    always_comb begin
        state_d = state_q;
        op_d = op_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        ce_d = ce_q;
        oe_d = oe_q;
        we_d = we_q;
        bsel_d = bsel_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        doe_d = doe_q;
        busy_oe_d = busy_oe_q;
        rsp_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                // Commands are taken only when the busy line and recovery allow.
                if (cmd_valid && access_ok) begin
                    op_d = cmd_op;
                    idx_d = 3'h0;
                    cnt_d = SETUP_CYC;
                    wdata_d = cmd_wdata;
                    if (cmd_op == OP_HW_STORE) begin
                        busy_oe_d = 1'b1;
                        cnt_d = REQUEST_CYC;
                        state_d = ST_HOLD_BUSY;
                    end else if (is_sequence(cmd_op)) begin
                        addr_d = ADDR_W'(seq_addr(3'h0, cmd_op));
                        bsel_d = 2'h0;
                        state_d = ST_SETUP;
                    end else begin
                        addr_d = cmd_addr;
                        bsel_d = cmd_byte_sel_n;
                        state_d = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                // Address stands before the cycle begins.
                if (cnt_q > 8'h01) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (op_q == OP_WRITE) begin
                    ce_d = 1'b0;
                    we_d = 1'b0;
                    oe_d = 1'b1;
                    doe_d = 1'b1;
                    cnt_d = PULSE_CYC;
                    state_d = ST_WRITE;
                end else begin
                    ce_d = 1'b0;
                    oe_d = 1'b0;
                    we_d = 1'b1;
                    cnt_d = ACCESS_CYC;
                    state_d = ST_READ;
                end
            end
            ST_READ: begin
                if (cnt_q > 8'h01) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    rdata_d = data_lines_in;
                    ce_d = 1'b1;
                    oe_d = 1'b1;
                    state_d = ST_END;
                end
            end
            ST_WRITE: begin
                if (cnt_q > 8'h01) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    // Address and data stay put while strobe and select rise.
                    ce_d = 1'b1;
                    we_d = 1'b1;
                    state_d = ST_END;
                end
            end
            ST_END: begin
                doe_d = 1'b0;
                if (is_sequence(op_q) && (idx_q != `SEQ_LAST_INDEX)) begin
                    // Sequence reads follow each other with nothing in between.
                    idx_d = idx_q + 3'h1;
                    addr_d = ADDR_W'(seq_addr(idx_q + 3'h1, op_q));
                    cnt_d = SETUP_CYC;
                    state_d = ST_SETUP;
                end else if (is_sequence(op_q)) begin
                    cnt_d = START_CYC;
                    state_d = ST_NV_WAIT;
                end else begin
                    rsp_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            ST_HOLD_BUSY: begin
                // Held past the request delay, then released so the device or
                // the pull-up can return the line high.
                if (cnt_q > 8'h01) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    busy_oe_d = 1'b0;
                    cnt_d = START_CYC;
                    state_d = ST_NV_WAIT;
                end
            end
            ST_NV_WAIT: begin
                // The guard only frees once the device ends busy and recovers.
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (access_ok) begin
                    rsp_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                ce_d = 1'b1;
                oe_d = 1'b1;
                we_d = 1'b1;
                doe_d = 1'b0;
                busy_oe_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            op_q <= OP_READ;
            cnt_q <= 8'h00;
            idx_q <= 3'h0;
            ce_q <= 1'b1;
            oe_q <= 1'b1;
            we_q <= 1'b1;
            bsel_q <= 2'h3;
            addr_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            doe_q <= 1'b0;
            busy_oe_q <= 1'b0;
            rsp_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            ce_q <= ce_d;
            oe_q <= oe_d;
            we_q <= we_d;
            bsel_q <= bsel_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            doe_q <= doe_d;
            busy_oe_q <= busy_oe_d;
            rsp_q <= rsp_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign cmd_ready = (state_q == ST_IDLE) && access_ok;
    assign rsp_valid = rsp_q;
    assign rsp_rdata = rdata_q;
    assign chip_sel_n = ce_q;
    assign out_en_n = oe_q;
    assign write_strobe_n = we_q;
    assign upper_byte_sel_n = bsel_q[1];
    assign lower_byte_sel_n = bsel_q[0];
    assign address_lines = addr_q;
    assign data_lines_out = wdata_q;
    assign data_lines_oe = doe_q;
    assign store_busy_n_out = 1'b0;
    assign store_busy_n_oe = busy_oe_q;

endmodule // nvsram_host_ctrl

// file: rtl/nvsram_host_consts.svh
/*
 * Pin timing counts and software sequence addresses for the nvSRAM host controller.
 * Assumes a 200 MHz clock; every time below is converted to cycles at that rate.
 */
`ifndef NVSRAM_HOST_CONSTS_SVH
`define NVSRAM_HOST_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 5

// ----------------------------------------------------------------------------
// Pin timing: least times round up to whole cycles
// ----------------------------------------------------------------------------
`define ADDR_SETUP_NS 5
`define ADDR_SETUP_CYC ((`ADDR_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDRESS_ACCESS_TIME_NS 45
`define ADDRESS_ACCESS_CYC ((`ADDRESS_ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_NS 30
`define WRITE_PULSE_CYC ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_REQUEST_NS 50
`define BUSY_REQUEST_CYC ((`BUSY_REQUEST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NV_START_NS 100
`define NV_START_CYC ((`NV_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POST_STORE_RECOVERY_TIME_NS 20000
`define POST_STORE_RECOVERY_CYC \
    ((`POST_STORE_RECOVERY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Software sequence addresses
// ----------------------------------------------------------------------------
`define SEQ_ADDR_0 16'h4E38
`define SEQ_ADDR_1 16'hB1C7
`define SEQ_ADDR_2 16'h83E0
`define SEQ_ADDR_3 16'h7C1F
`define SEQ_ADDR_4 16'h703F
`define SEQ_LAST_STORE 16'h8FC0
`define SEQ_LAST_RECALL 16'h4C63
`define SEQ_LAST_PFS_OFF 16'h8B45
`define SEQ_LAST_PFS_ON 16'h4B46
`define SEQ_LAST_INDEX 3'h5

`endif

// file: rtl/nvsram_host_pkg.sv
/*
 * Types shared by the nvSRAM host controller files.
 * Assumes nothing of its surroundings.
 */
package nvsram_host_pkg;

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_WRITE = 3'h1,
        OP_SW_STORE = 3'h2,
        OP_SW_RECALL = 3'h3,
        OP_PFS_DISABLE = 3'h4,
        OP_PFS_ENABLE = 3'h5,
        OP_HW_STORE = 3'h6
    } op_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SETUP = 3'h1,
        ST_READ = 3'h2,
        ST_WRITE = 3'h3,
        ST_END = 3'h4,
        ST_HOLD_BUSY = 3'h5,
        ST_NV_WAIT = 3'h6
    } state_e;

endpackage

// file: rtl/busy_guard.sv
/*
 * Watches the store busy line and says when the memory may be accessed again.
 * Assumes the busy input is synchronous to clk and already resolved from all drivers.
 */
`include "nvsram_host_consts.svh"

module busy_guard #(
    parameter int RECOVERY_CYC = `POST_STORE_RECOVERY_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic store_busy_n_in,
    output logic access_ok
);

    logic [15:0] wait_q;
    logic [15:0] wait_d;

    // The count starts full so that the power-up recall, which holds the line low
    // right after reset, is also followed by the recovery interval.
    always_comb begin
        if (!store_busy_n_in) begin
            wait_d = 16'(RECOVERY_CYC);
        end else if (wait_q != 16'h0000) begin
            wait_d = wait_q - 16'h0001;
        end else begin
            wait_d = wait_q;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_q <= 16'(RECOVERY_CYC);
        end else begin
            wait_q <= wait_d;
        end
    end

    // Accesses wait while the line is low and for the recovery time after it rises.
    assign access_ok = store_busy_n_in && (wait_q == 16'h0000);

endmodule // busy_guard

// file: bench/nvsram_ctrl_sva.sv
/* Pin-level checker for the nvSRAM host controller.
   Assumes it is bound into nvsram_host_ctrl with busy already resolved. */
module nvsram_ctrl_sva #(
    parameter int ADDR_W = 19,
    parameter int RECOVERY_CYC = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cmd_ready,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_strobe_n,
    input wire logic [ADDR_W-1:0] address_lines,
    input wire logic data_lines_oe,
    input wire logic store_busy_n_in,
    input wire logic store_busy_n_out,
    input wire logic store_busy_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Cycles the busy line has been high; the guard is judged against it.
    int hi_q;
    int hi_d;
    always_comb begin
        hi_d = store_busy_n_in ? hi_q + 1 : 0;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hi_q <= 0;
        end else begin
            hi_q <= hi_d;
        end
    end
    property p_read_we_high;
        !chip_sel_n && !out_en_n |-> write_strobe_n && !data_lines_oe;
    endproperty
    a_read_we_high: assert property (p_read_we_high) else $error("read with strobe low");
    property p_write_oe_high;
        !write_strobe_n |-> out_en_n && !chip_sel_n;
    endproperty
    a_write_oe_high: assert property (p_write_oe_high) else $error("write with oe low");
    property p_addr_hold;
        !write_strobe_n || $rose(write_strobe_n) |-> $stable(address_lines);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved in write");
    property p_read_len;
        $fell(out_en_n) |-> ##8 !out_en_n ##1 out_en_n;
    endproperty
    a_read_len: assert property (p_read_len) else $error("read length wrong");
    property p_write_len;
        $fell(write_strobe_n) |-> !write_strobe_n [*6] ##1 write_strobe_n;
    endproperty
    a_write_len: assert property (p_write_len) else $error("strobe length wrong");
    property p_guard;
        cmd_ready |-> store_busy_n_in && hi_q >= RECOVERY_CYC;
    endproperty
    a_guard: assert property (p_guard) else $error("ready too early");
    property p_no_start_busy;
        $fell(chip_sel_n) |-> store_busy_n_in;
    endproperty
    a_no_start_busy: assert property (p_no_start_busy) else $error("access while busy");
    property p_pin_pulse;
        $rose(store_busy_n_oe) |-> ##9 store_busy_n_oe ##1 !store_busy_n_oe;
    endproperty
    a_pin_pulse: assert property (p_pin_pulse) else $error("request pulse wrong");
    property p_open_drain;
        store_busy_n_oe |-> !store_busy_n_out && chip_sel_n;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("busy driven high");
endmodule // nvsram_ctrl_sva

bind nvsram_host_ctrl nvsram_ctrl_sva #(.ADDR_W(ADDR_W), .RECOVERY_CYC(RECOVERY_CYC)) u_sva (
    .clk, .resetn, .cmd_ready, .chip_sel_n, .out_en_n, .write_strobe_n, .address_lines,
    .data_lines_oe, .store_busy_n_in, .store_busy_n_out, .store_busy_n_oe);

// file: bench/nvsram_model.sv
/* Behavioural nvSRAM seen through its pins, with a small aliased array.
   Assumes pins change on clk edges and the bench resolves the shared lines. */
module nvsram_model #(
    parameter int STORE_CYC = 40,
    parameter int RECALL_CYC = 30,
    parameter int REQ_CYC = 4,
    parameter int HIGH_CYC = 2
) (
    input wire logic clk,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_strobe_n,
    input wire logic upper_byte_sel_n,
    input wire logic lower_byte_sel_n,
    input wire logic [18:0] address_lines,
    input wire logic [15:0] data_lines,
    input wire logic store_busy_n,
    output logic [15:0] dq_drive,
    output logic busy_pull_low,
    output logic busy_drive_high
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] SEQ [5] = '{16'h4E38, 16'hB1C7, 16'h83E0, 16'h7C1F, 16'h703F};
    localparam logic [15:0] L_ST = 16'h8FC0;
    localparam logic [15:0] L_RC = 16'h4C63;
    localparam logic [15:0] L_OFF = 16'h8B45;
    localparam logic [15:0] L_ON = 16'h4B46;
    logic [15:0] mem [256] = '{default: 16'h0000};
    logic [15:0] word, last_q = 16'h0000, wr_d_q;
    logic [18:0] rd_a_q;
    logic [7:0] wr_a_q;
    logic [1:0] wr_s_q;
    logic rd, wr, rd_q = 1'b0, wr_q = 1'b0, wflag = 1'b0, nv_store = 1'b0;
    logic pfs_en = 1'b1;
    int idx = 0, req_cnt = 0, n_store = 0, n_recall = 0, hi_cnt = 0;
    int nv_cnt = RECALL_CYC;
    assign busy_pull_low = nv_cnt > 0;
    // Only stores end with the short active high drive; a recall just lets go.
    assign busy_drive_high = hi_cnt > 0;
    assign rd = !chip_sel_n && !out_en_n && write_strobe_n && store_busy_n;
    assign wr = !chip_sel_n && !write_strobe_n && store_busy_n;
    assign word = mem[address_lines[7:0]];
    // Idle or unselected lanes show the inverse of the last level, so stale data never matches.
    assign dq_drive = {rd && !upper_byte_sel_n ? word[15:8] : ~last_q[15:8],
                       rd && !lower_byte_sel_n ? word[7:0] : ~last_q[7:0]};
    task automatic start_nv(input int cyc, input logic st);
        nv_cnt <= cyc;
        nv_store <= st;
        wflag <= 1'b0;
    endtask
    always @(posedge clk) begin
        last_q <= data_lines;
        rd_q <= rd;
        wr_q <= wr;
        if (rd) rd_a_q <= address_lines;
        if (wr) begin
            wr_a_q <= address_lines[7:0];
            wr_d_q <= data_lines;
            wr_s_q <= {upper_byte_sel_n, lower_byte_sel_n};
        end
        if (nv_cnt > 0) nv_cnt <= nv_cnt - 1;
        if (nv_cnt == 1 && nv_store) begin
            hi_cnt <= HIGH_CYC;
        end else if (hi_cnt > 0) begin
            hi_cnt <= hi_cnt - 1;
        end
        req_cnt <= (!store_busy_n && nv_cnt == 0) ? req_cnt + 1 : 0;
        if (req_cnt == REQ_CYC && wflag) begin
            start_nv(STORE_CYC, 1'b1);
            n_store++;
        end
        if (wr_q && !wr) begin
            if (!wr_s_q[1]) mem[wr_a_q][15:8] <= wr_d_q[15:8];
            if (!wr_s_q[0]) mem[wr_a_q][7:0] <= wr_d_q[7:0];
            wflag <= 1'b1;
            idx <= 0;
        end
        if (rd_q && !rd) begin
            if (idx == 5) begin
                idx <= 0;
                case (rd_a_q[14:2])
                    L_ST[14:2]: begin
                        start_nv(STORE_CYC, 1'b1);
                        n_store++;
                    end
                    L_RC[14:2]: begin
                        start_nv(RECALL_CYC, 1'b0);
                        n_recall++;
                    end
                    L_OFF[14:2]: pfs_en <= 1'b0;
                    L_ON[14:2]: pfs_en <= 1'b1;
                    default: ;
                endcase
            end else if (rd_a_q[14:2] == SEQ[idx][14:2]) begin
                idx <= idx + 1;
            end else begin
                idx <= (rd_a_q[14:2] == SEQ[0][14:2]) ? 1 : 0;
            end
        end
    end
endmodule // nvsram_model

// file: bench/tb_top.sv
/* Self-checking bench: controller against the behavioural device model.
   Assumes a 200 MHz clock and a short recovery count for simulation. */
module tb_top
    import nvsram_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIM = 20000;
    logic clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0;
    op_e cmd_op = OP_READ;
    logic [18:0] cmd_addr = 19'h00000, address_lines;
    logic [15:0] cmd_wdata = 16'h0000, rsp_rdata, data_lines_out, dq_drive, data_lines;
    logic [1:0] cmd_byte_sel_n = 2'h3;
    logic cmd_ready, rsp_valid, chip_sel_n, out_en_n, write_strobe_n, data_lines_oe;
    logic upper_byte_sel_n, lower_byte_sel_n, store_busy_n_out, store_busy_n_oe;
    logic busy_pull_low, busy_drive_high, store_busy_n;
    int n_fail = 0, samples_checked = 0;
    always #2.5 clk = ~clk;
    assign data_lines = data_lines_oe ? data_lines_out : dq_drive;
    // Open drain with pull-up: high unless either party pulls it low.
    // The device's brief high drive after a store overrides either party pulling it low.
    assign store_busy_n = busy_drive_high ||
                          !((store_busy_n_oe && !store_busy_n_out) || busy_pull_low);
    nvsram_host_ctrl #(.RECOVERY_CYC(8)) uut (
        .clk, .resetn, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_wdata,
        .cmd_byte_sel_n, .rsp_valid, .rsp_rdata, .chip_sel_n, .out_en_n, .write_strobe_n,
        .upper_byte_sel_n, .lower_byte_sel_n, .address_lines, .data_lines_in(data_lines),
        .data_lines_out, .data_lines_oe, .store_busy_n_in(store_busy_n), .store_busy_n_out,
        .store_busy_n_oe);
    nvsram_model u_dev (
        .clk, .chip_sel_n, .out_en_n, .write_strobe_n, .upper_byte_sel_n,
        .lower_byte_sel_n, .address_lines, .data_lines, .store_busy_n, .dq_drive,
        .busy_pull_low, .busy_drive_high);
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_up(input int k);
        if (k >= LIM) begin
            n_fail++;
            conclude();
        end
    endtask
    // Drives at the falling edge; the request is held until the rising edge that takes it.
    task automatic run_cmd(input op_e op, input logic [18:0] a, input logic [15:0] d,
                           input logic [1:0] s);
        int k;
        @(negedge clk);
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_byte_sel_n = s;
        cmd_valid = 1'b1;
        for (k = 0; k < LIM && cmd_ready !== 1'b1; k++) @(negedge clk);
        give_up(k);
        @(negedge clk);
        cmd_valid = 1'b0;
        for (k = 0; k < LIM && rsp_valid !== 1'b1; k++) @(negedge clk);
        give_up(k);
    endtask
    task automatic t_rw();
        run_cmd(OP_WRITE, 19'h00012, 16'hA55A, 2'h0);
        run_cmd(OP_WRITE, 19'h00012, 16'h3CC3, 2'h1);
        run_cmd(OP_READ, 19'h00012, 16'h0000, 2'h0);
        check("read word", rsp_rdata, 16'h3C5A);
        run_cmd(OP_READ, 19'h00012, 16'h0000, 2'h2);
        check("low lane", rsp_rdata[7:0], 8'h5A);
        $display("test rw done");
    endtask
    task automatic t_seq();
        op_e ops [4] = '{OP_PFS_DISABLE, OP_PFS_ENABLE, OP_SW_RECALL, OP_SW_STORE};
        int s0, r0;
        foreach (ops[i]) begin
            s0 = u_dev.n_store;
            r0 = u_dev.n_recall;
            run_cmd(ops[i], 19'h00000, 16'h0000, 2'h3);
            check("stores", u_dev.n_store, s0 + (ops[i] == OP_SW_STORE));
            check("recalls", u_dev.n_recall, r0 + (ops[i] == OP_SW_RECALL));
            check("power fail store", u_dev.pfs_en, ops[i] != OP_PFS_DISABLE);
        end
        $display("test sequences done");
    endtask
    task automatic t_pin();
        int s0;
        s0 = u_dev.n_store;
        run_cmd(OP_HW_STORE, 19'h00000, 16'h0000, 2'h3);
        check("pin store idle", u_dev.n_store, s0);
        run_cmd(OP_WRITE, 19'h00034, 16'h1234, 2'h0);
        run_cmd(OP_HW_STORE, 19'h00000, 16'h0000, 2'h3);
        check("pin store", u_dev.n_store, s0 + 1);
        run_cmd(OP_READ, 19'h00034, 16'h0000, 2'h0);
        check("read after store", rsp_rdata, 16'h1234);
        $display("test pin store done");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        t_rw();
        t_seq();
        t_pin();
        conclude();
    end
endmodule // tb_top
